// File: hw/mem_ref_relay.sv
// memory reference relay: path ports, relay slices, credit handshake and chip sparing
// How it works
// - transmitters count outstanding references and send only below the receiver's buffer count
// - each valid strobe sent raises the transmitter's outstanding count by one
// - a reference leaving a buffer returns one credit pulse; its sender then counts down
// - read return tag rides in the write-data field and comes back with data
// - read data go back as one full 76-bit word with strobe, control, tag
// - eight independent processor path ports, one per processor access path
// - reads forward only control, address and tag, no write data
// - two slices per path: even low half, odd high half of bits
// - each slice feeds four crossbar units and returns read data to its port
// - each slice buffers six entries each direction in strict arrival order
// - references advance by valid strobes and credit returns while an entry is free
// - lower half-stack spans eighteen data chips, upper twenty, each with one spare
// - one flawed chip per half-stack; later flaws are refused
// - a flawed chip's bits and its chain move two chips onward
// - lower half-stack chains end at chips 16 and 17 and land on its spare
// - upper chains run through chips 18 and 19 before reaching its spare
// - lower spare covers 18 chips, upper spare covers 20 chips
// - write flag set means two packets follow, clear means one
`timescale 1ns/1ps
`default_nettype none
module mem_ref_relay
	import mem_relay_pkg::*;
#(
	parameter int XBAR_CREDITS = XBAR_BUFS,
	parameter int PROC_CREDITS = PROC_BUFS
)
(
	input  wire logic                                 core_clk,
	input  wire logic                                 resetn,
	input  wire logic      [NUM_PATHS-1:0]            req_valid,
	input  wire ref_ctrl_t [NUM_PATHS-1:0]            req_ctrl,
	input  wire logic      [NUM_PATHS-1:0][ADDR_W-1:0] req_addr,
	input  wire logic      [NUM_PATHS-1:0][PKT_W-1:0] req_pkt,
	output logic           [NUM_PATHS-1:0]            req_resume,
	output logic           [NUM_PATHS-1:0][XBAR_UNITS-1:0] xbar_valid,
	output mem_ref_t       [NUM_PATHS-1:0]            xbar_ref,
	input  wire logic      [NUM_PATHS-1:0][XBAR_UNITS-1:0] xbar_resume,
	input  wire logic      [NUM_PATHS-1:0]            ret_valid,
	input  wire mem_ret_t  [NUM_PATHS-1:0]            ret_data,
	output logic           [NUM_PATHS-1:0]            ret_resume,
	output logic           [NUM_PATHS-1:0]            rsp_valid,
	output mem_ret_t       [NUM_PATHS-1:0]            rsp_data,
	input  wire logic      [NUM_PATHS-1:0]            rsp_resume,
	input  wire logic                                 maint_set,
	input  wire logic                                 maint_clear,
	input  wire logic                                 maint_upper,
	input  wire logic      [CHIP_SEL_W-1:0]           maint_chip,
	output spare_cfg_t                                flaw_lo,
	output spare_cfg_t                                flaw_hi,
	input  wire logic      [LO_CHIPS*CHIP_W-1:0]      stack_wr_lo_log,
	output logic           [(LO_CHIPS+1)*CHIP_W-1:0]  stack_wr_lo_phys,
	input  wire logic      [HI_CHIPS*CHIP_W-1:0]      stack_wr_hi_log,
	output logic           [(HI_CHIPS+1)*CHIP_W-1:0]  stack_wr_hi_phys,
	input  wire logic      [(LO_CHIPS+1)*CHIP_W-1:0]  stack_rd_lo_phys,
	output logic           [LO_CHIPS*CHIP_W-1:0]      stack_rd_lo_log,
	input  wire logic      [(HI_CHIPS+1)*CHIP_W-1:0]  stack_rd_hi_phys,
	output logic           [HI_CHIPS*CHIP_W-1:0]      stack_rd_hi_log
);
	typedef struct packed {
		path_state_t [NUM_PATHS-1:0]      path;
		spare_cfg_t                       cfg_lo;
		spare_cfg_t                       cfg_hi;
		logic [(LO_CHIPS+1)*CHIP_W-1:0]   wr_lo_phys;
		logic [(HI_CHIPS+1)*CHIP_W-1:0]   wr_hi_phys;
		logic [LO_CHIPS*CHIP_W-1:0]       rd_lo_log;
		logic [HI_CHIPS*CHIP_W-1:0]       rd_hi_log;
	} relay_state_t;

	relay_state_t                   st_reg;
	relay_state_t                   st_next;

	// capture hand-off toward the inbound slices
	logic       [NUM_PATHS-1:0]     push;
	mem_ref_t   [NUM_PATHS-1:0]     push_ref;
	logic       [NUM_PATHS-1:0]     pop_in;
	logic       [NUM_PATHS-1:0]     pop_ret;
	mem_ref_t   [NUM_PATHS-1:0]     head;
	logic       [NUM_PATHS-1:0][1:0] dest;

	// inbound slice handshakes, even and odd kept in step
	logic       [NUM_PATHS-1:0]     ev_rdy;
	logic       [NUM_PATHS-1:0]     od_rdy;
	logic       [NUM_PATHS-1:0]     ev_vld;
	logic       [NUM_PATHS-1:0]     od_vld;
	slice_ref_t [NUM_PATHS-1:0]     ev_out;
	slice_ref_t [NUM_PATHS-1:0]     od_out;

	// return slice handshakes
	logic       [NUM_PATHS-1:0]     evr_vld;
	logic       [NUM_PATHS-1:0]     odr_vld;
	slice_ret_t [NUM_PATHS-1:0]     evr_out;
	slice_ret_t [NUM_PATHS-1:0]     odr_out;
	logic       [NUM_PATHS-1:0]     evr_rdy;
	logic       [NUM_PATHS-1:0]     odr_rdy;

	// lane steering of both half-stacks
	logic [(LO_CHIPS+1)*CHIP_W-1:0] lo_wr_phys;
	logic [(HI_CHIPS+1)*CHIP_W-1:0] hi_wr_phys;
	logic [LO_CHIPS*CHIP_W-1:0]     lo_rd_log;
	logic [HI_CHIPS*CHIP_W-1:0]     hi_rd_log;

	// per path: even and odd slices, each with an inbound and a return buffer
	for (genvar p = 0; p < NUM_PATHS; p++)
	begin : g_path
		relay_fifo #(.WIDTH($bits(slice_ref_t)), .DEPTH(SLICE_DEPTH)) u_in_even (
			.core_clk  (core_clk),
			.resetn    (resetn),
			.in_valid  (push[p] && od_rdy[p]),
			.in_ready  (ev_rdy[p]),
			.in_data   (split_ref(push_ref[p], 1'b0)),
			.out_valid (ev_vld[p]),
			.out_ready (pop_in[p]),
			.out_data  (ev_out[p])
		);

		relay_fifo #(.WIDTH($bits(slice_ref_t)), .DEPTH(SLICE_DEPTH)) u_in_odd (
			.core_clk  (core_clk),
			.resetn    (resetn),
			.in_valid  (push[p] && ev_rdy[p]),
			.in_ready  (od_rdy[p]),
			.in_data   (split_ref(push_ref[p], 1'b1)),
			.out_valid (od_vld[p]),
			.out_ready (pop_in[p]),
			.out_data  (od_out[p])
		);

		relay_fifo #(.WIDTH($bits(slice_ret_t)), .DEPTH(SLICE_DEPTH)) u_ret_even (
			.core_clk  (core_clk),
			.resetn    (resetn),
			.in_valid  (ret_valid[p] && odr_rdy[p]),
			.in_ready  (evr_rdy[p]),
			.in_data   (split_ret(ret_data[p], 1'b0)),
			.out_valid (evr_vld[p]),
			.out_ready (pop_ret[p]),
			.out_data  (evr_out[p])
		);

		relay_fifo #(.WIDTH($bits(slice_ret_t)), .DEPTH(SLICE_DEPTH)) u_ret_odd (
			.core_clk  (core_clk),
			.resetn    (resetn),
			.in_valid  (ret_valid[p] && evr_rdy[p]),
			.in_ready  (odr_rdy[p]),
			.in_data   (split_ret(ret_data[p], 1'b1)),
			.out_valid (odr_vld[p]),
			.out_ready (pop_ret[p]),
			.out_data  (odr_out[p])
		);

		assign xbar_valid[p] = st_reg.path[p].xbar_valid;
		assign xbar_ref[p]   = st_reg.path[p].xbar_ref;
		assign rsp_valid[p]  = st_reg.path[p].rsp_valid;
		assign rsp_data[p]   = st_reg.path[p].rsp;
	end

	spare_shift #(.N(LO_CHIPS)) u_spare_lo (
		.cfg     (st_reg.cfg_lo),
		.wr_log  (stack_wr_lo_log),
		.wr_phys (lo_wr_phys),
		.rd_phys (stack_rd_lo_phys),
		.rd_log  (lo_rd_log)
	);
	spare_shift #(.N(HI_CHIPS)) u_spare_hi (
		.cfg     (st_reg.cfg_hi),
		.wr_log  (stack_wr_hi_log),
		.wr_phys (hi_wr_phys),
		.rd_phys (stack_rd_hi_phys),
		.rd_log  (hi_rd_log)
	);

	assign req_resume       = pop_in;
	assign ret_resume       = pop_ret;
	assign flaw_lo          = st_reg.cfg_lo;
	assign flaw_hi          = st_reg.cfg_hi;
	assign stack_wr_lo_phys = st_reg.wr_lo_phys;
	assign stack_wr_hi_phys = st_reg.wr_hi_phys;
	assign stack_rd_lo_log  = st_reg.rd_lo_log;
	assign stack_rd_hi_log  = st_reg.rd_hi_log;

	always_comb
	begin
		st_next = st_reg;
		for (int p = 0; p < NUM_PATHS; p++)
		begin
			push[p]     = 1'b0;
			push_ref[p] = st_reg.path[p].held;
			pop_in[p]   = 1'b0;
			pop_ret[p]  = 1'b0;
			head[p]     = join_ref(ev_out[p], od_out[p]);
			dest[p]     = head[p].ctrl.bank[3:2];
			// capture: strobe, control, address and first packet together
			unique case (st_reg.path[p].cap)
				CAP_IDLE:
				begin
					if (req_valid[p])
					begin
						push_ref[p].ctrl = req_ctrl[p];
						push_ref[p].addr = req_addr[p];
						push_ref[p].word = place_packet('0, req_pkt[p], 1'b0);
						st_next.path[p].held = push_ref[p];
						if (req_ctrl[p].write)
							st_next.path[p].cap = CAP_PKT2;
						else
							push[p] = 1'b1;
					end
				end
				// packet two is taken unconditionally; a strobe now is ignored
				CAP_PKT2:
				begin
					push_ref[p].word = place_packet(st_reg.path[p].held.word, req_pkt[p], 1'b1);
					push[p] = 1'b1;
					st_next.path[p].cap = CAP_IDLE;
				end
			endcase

			// relay toward the crossbar unit chosen by the upper bank bits
			st_next.path[p].xbar_valid = '0;
			if (ev_vld[p] && od_vld[p]
				&& st_reg.path[p].xbar_cnt[dest[p]] < CNT_W'(XBAR_CREDITS))
			begin
				pop_in[p] = 1'b1;
				st_next.path[p].xbar_valid[dest[p]] = 1'b1;
				st_next.path[p].xbar_ref = head[p];
			end
			// a send and a credit return in one cycle leave the count as is
			for (int u = 0; u < XBAR_UNITS; u++)
				st_next.path[p].xbar_cnt[u] = credit(st_reg.path[p].xbar_cnt[u],
					pop_in[p] && dest[p] == 2'(u), xbar_resume[p][u]);

			// return read data toward the processor port
			st_next.path[p].rsp_valid = 1'b0;
			if (evr_vld[p] && odr_vld[p] && st_reg.path[p].rsp_cnt < CNT_W'(PROC_CREDITS))
			begin
				pop_ret[p] = 1'b1;
				st_next.path[p].rsp_valid = 1'b1;
				st_next.path[p].rsp = join_ret(evr_out[p], odr_out[p]);
			end
			st_next.path[p].rsp_cnt = credit(st_reg.path[p].rsp_cnt, pop_ret[p], rsp_resume[p]);
		end

		// maintenance flaw setting; a second flaw is refused until cleared
		if (maint_clear)
		begin
			if (maint_upper)
				st_next.cfg_hi.en = 1'b0;
			else
				st_next.cfg_lo.en = 1'b0;
		end
		else if (maint_set)
		begin
			if (maint_upper && !st_reg.cfg_hi.en && maint_chip < CHIP_SEL_W'(HI_CHIPS))
				st_next.cfg_hi = '{en: 1'b1, chip: maint_chip};
			else if (!maint_upper && !st_reg.cfg_lo.en && maint_chip < CHIP_SEL_W'(LO_CHIPS))
				st_next.cfg_lo = '{en: 1'b1, chip: maint_chip};
		end

		// registered lanes keep stack pins free of steering glitches
		st_next.wr_lo_phys = lo_wr_phys;
		st_next.wr_hi_phys = hi_wr_phys;
		st_next.rd_lo_log  = lo_rd_log;
		st_next.rd_hi_log  = hi_rd_log;
	end

	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end
endmodule : mem_ref_relay
`default_nettype wire

// File: hw/mem_relay_pkg.sv
// shared constants, types and helpers of the memory reference relay
package mem_relay_pkg;
	localparam int NUM_PATHS   = 8;
	localparam int PKT_W       = 38;
	localparam int WORD_W      = 76;
	localparam int ADDR_W      = 25;
	localparam int TAG_W       = 38;
	localparam int EVEN_ADDR_W = 12;
	localparam int HALF_ADDR_W = 13;
	localparam int HALF_DATA_W = 32;
	localparam int HALF_CHK_W  = 6;
	localparam int HALF_TAG_W  = 19;
	localparam int SLICE_DEPTH = 6;
	localparam int XBAR_UNITS  = 4;
	localparam int XBAR_BUFS   = 4;
	localparam int PROC_BUFS   = 6;
	localparam int CNT_W       = 3;
	localparam int LO_CHIPS    = 18;
	localparam int HI_CHIPS    = 20;
	localparam int CHIP_W      = 4;
	localparam int CHIP_SEL_W  = 5;
	localparam int CHAIN_STEP  = 2;
	// word field positions
	localparam int DATA_LO_POS = 0;
	localparam int DATA_HI_POS = 32;
	localparam int CHK_LO_POS  = 64;
	localparam int CHK_HI_POS  = 70;
	localparam int SEG_W       = 16;
	localparam int CSEG_W      = 3;
	// packet field positions
	localparam int PKT_D_HI    = 16;
	localparam int PKT_C_LO    = 32;
	localparam int PKT_C_HI    = 35;

	typedef struct packed {
		logic [3:0] bank;
		logic       write;
		logic [3:0] kind;
	} ref_ctrl_t;

	typedef struct packed {
		ref_ctrl_t           ctrl;
		logic [ADDR_W-1:0]   addr;
		logic [WORD_W-1:0]   word;
	} mem_ref_t;

	typedef struct packed {
		ref_ctrl_t           ctrl;
		logic [TAG_W-1:0]    tag;
		logic [WORD_W-1:0]   word;
	} mem_ret_t;

	typedef struct packed {
		logic                   write;
		logic [1:0]             bank;
		logic [1:0]             kind;
		logic [HALF_ADDR_W-1:0] addr;
		logic [HALF_DATA_W-1:0] data;
		logic [HALF_CHK_W-1:0]  check;
	} slice_ref_t;

	typedef struct packed {
		logic                   write;
		logic [1:0]             bank;
		logic [1:0]             kind;
		logic [HALF_TAG_W-1:0]  tag;
		logic [HALF_DATA_W-1:0] data;
		logic [HALF_CHK_W-1:0]  check;
	} slice_ret_t;

	typedef struct packed {
		logic                  en;
		logic [CHIP_SEL_W-1:0] chip;
	} spare_cfg_t;

	typedef enum logic [0:0] {
		CAP_IDLE = 1'b0,
		CAP_PKT2 = 1'b1
	} cap_state_t;

	function automatic logic [WORD_W-1:0] place_packet(input logic [WORD_W-1:0] w,
		input logic [PKT_W-1:0] pkt, input logic second);
		logic [WORD_W-1:0] r;
		int d;
		int c;
		r = w;
		d = second ? SEG_W : 0;
		c = second ? CSEG_W : 0;
		r[DATA_LO_POS+d +: SEG_W]  = pkt[0 +: SEG_W];
		r[DATA_HI_POS+d +: SEG_W]  = pkt[PKT_D_HI +: SEG_W];
		r[CHK_LO_POS+c +: CSEG_W]  = pkt[PKT_C_LO +: CSEG_W];
		r[CHK_HI_POS+c +: CSEG_W]  = pkt[PKT_C_HI +: CSEG_W];
		return r;
	endfunction : place_packet

	function automatic slice_ref_t split_ref(input mem_ref_t r, input logic odd);
		slice_ref_t s;
		s.write = r.ctrl.write;
		s.bank  = odd ? r.ctrl.bank[3:2] : r.ctrl.bank[1:0];
		s.kind  = odd ? r.ctrl.kind[3:2] : r.ctrl.kind[1:0];
		s.addr  = odd ? r.addr[ADDR_W-1:EVEN_ADDR_W] : {1'b0, r.addr[EVEN_ADDR_W-1:0]};
		s.data  = odd ? r.word[DATA_HI_POS +: HALF_DATA_W] : r.word[DATA_LO_POS +: HALF_DATA_W];
		s.check = odd ? r.word[CHK_HI_POS +: HALF_CHK_W] : r.word[CHK_LO_POS +: HALF_CHK_W];
		return s;
	endfunction : split_ref

	function automatic mem_ref_t join_ref(input slice_ref_t ev, input slice_ref_t od);
		mem_ref_t r;
		r.ctrl = '{bank: {od.bank, ev.bank}, write: ev.write, kind: {od.kind, ev.kind}};
		r.addr = {od.addr, ev.addr[EVEN_ADDR_W-1:0]};
		r.word = {od.check, ev.check, od.data, ev.data};
		return r;
	endfunction : join_ref

	function automatic slice_ret_t split_ret(input mem_ret_t r, input logic odd);
		slice_ret_t s;
		s.write = r.ctrl.write;
		s.bank  = odd ? r.ctrl.bank[3:2] : r.ctrl.bank[1:0];
		s.kind  = odd ? r.ctrl.kind[3:2] : r.ctrl.kind[1:0];
		s.tag   = odd ? r.tag[TAG_W-1:HALF_TAG_W] : r.tag[HALF_TAG_W-1:0];
		s.data  = odd ? r.word[DATA_HI_POS +: HALF_DATA_W] : r.word[DATA_LO_POS +: HALF_DATA_W];
		s.check = odd ? r.word[CHK_HI_POS +: HALF_CHK_W] : r.word[CHK_LO_POS +: HALF_CHK_W];
		return s;
	endfunction : split_ret

	function automatic mem_ret_t join_ret(input slice_ret_t ev, input slice_ret_t od);
		mem_ret_t r;
		r.ctrl = '{bank: {od.bank, ev.bank}, write: ev.write, kind: {od.kind, ev.kind}};
		r.tag  = {od.tag, ev.tag};
		r.word = {od.check, ev.check, od.data, ev.data};
		return r;
	endfunction : join_ret

	function automatic logic [CNT_W-1:0] credit(input logic [CNT_W-1:0] cnt, input logic inc,
		input logic dec);
		logic [CNT_W-1:0] r;
		r = cnt;
		if (inc && !dec)
			r = cnt + 1'b1;
		else if (dec && !inc)
			r = cnt - 1'b1;
		return r;
	endfunction : credit

	typedef struct packed {
		cap_state_t                           cap;
		mem_ref_t                             held;
		logic [XBAR_UNITS-1:0][CNT_W-1:0]     xbar_cnt;
		logic [XBAR_UNITS-1:0]                xbar_valid;
		mem_ref_t                             xbar_ref;
		logic [CNT_W-1:0]                     rsp_cnt;
		logic                                 rsp_valid;
		mem_ret_t                             rsp;
	} path_state_t;
endpackage : mem_relay_pkg

// File: hw/relay_fifo.sv
// first-in first-out buffer of one relay slice direction, inbound or return
`timescale 1ns/1ps
`default_nettype none
module relay_fifo
	import mem_relay_pkg::*;
#(
	parameter int WIDTH = 8,
	parameter int DEPTH = SLICE_DEPTH
)
(
	input  wire logic             core_clk,
	input  wire logic             resetn,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int PW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [PW-1:0]               wr_ptr;
		logic [PW-1:0]               rd_ptr;
		logic [CW-1:0]               count;
	} fifo_state_t;

	fifo_state_t st_reg;
	fifo_state_t st_next;
	logic        push;
	logic        pop;

	function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
		return (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
	endfunction : bump

	assign in_ready  = st_reg.count != CW'(DEPTH);
	assign out_valid = st_reg.count != '0;
	assign out_data  = st_reg.mem[st_reg.rd_ptr];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	always_comb
	begin
		st_next = st_reg;
		if (push)
		begin
			st_next.mem[st_reg.wr_ptr] = in_data;
			st_next.wr_ptr = bump(st_reg.wr_ptr);
		end
		if (pop)
			st_next.rd_ptr = bump(st_reg.rd_ptr);
		if (push && !pop)
			st_next.count = st_reg.count + 1'b1;
		else if (pop && !push)
			st_next.count = st_reg.count - 1'b1;
	end

	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end
endmodule : relay_fifo
`default_nettype wire

// File: hw/spare_shift.sv
// chip lane steering of one half-stack around one flawed chip
`timescale 1ns/1ps
`default_nettype none
module spare_shift
	import mem_relay_pkg::*;
#(
	parameter int N = LO_CHIPS
)
(
	input  wire spare_cfg_t              cfg,
	input  wire logic [N*CHIP_W-1:0]     wr_log,
	output logic      [(N+1)*CHIP_W-1:0] wr_phys,
	input  wire logic [(N+1)*CHIP_W-1:0] rd_phys,
	output logic      [N*CHIP_W-1:0]     rd_log
);
	// top lane is the spare chip; lanes are logical chip indices of this half-stack
	always_comb
	begin
		int f;
		f = int'(cfg.chip);
		wr_phys = '0;
		rd_log  = '0;
		for (int c = 0; c < N; c++)
		begin
			if (cfg.en && c >= f && (c % CHAIN_STEP) == (f % CHAIN_STEP))
			begin
				// the chain of the flawed chip moves two positions on
				if (c > f)
					wr_phys[c*CHIP_W +: CHIP_W] = wr_log[(c-CHAIN_STEP)*CHIP_W +: CHIP_W];
				if (c + CHAIN_STEP < N)
					rd_log[c*CHIP_W +: CHIP_W] = rd_phys[(c+CHAIN_STEP)*CHIP_W +: CHIP_W];
				else
				begin
					// last chip of the chain lands on the spare
					rd_log[c*CHIP_W +: CHIP_W]  = rd_phys[N*CHIP_W +: CHIP_W];
					wr_phys[N*CHIP_W +: CHIP_W] = wr_log[c*CHIP_W +: CHIP_W];
				end
			end
			else
			begin
				wr_phys[c*CHIP_W +: CHIP_W] = wr_log[c*CHIP_W +: CHIP_W];
				rd_log[c*CHIP_W +: CHIP_W]  = rd_phys[c*CHIP_W +: CHIP_W];
			end
		end
	end
endmodule : spare_shift
`default_nettype wire

// File: sim/mem_ref_relay_assertions.sv
// assertion checker of the memory reference relay, path 0 and lower half-stack, plus reset state of all paths and both half-stacks
`timescale 1ns/1ps
`default_nettype none
module mem_ref_relay_assertions
	import mem_relay_pkg::*;
(
	input wire logic					core_clk,
	input wire logic					resetn,
	input wire logic	[NUM_PATHS-1:0]			req_resume,
	input wire logic	[NUM_PATHS-1:0][XBAR_UNITS-1:0]	xbar_valid,
	input wire mem_ref_t	[NUM_PATHS-1:0]			xbar_ref,
	input wire logic	[NUM_PATHS-1:0]			ret_resume,
	input wire logic	[NUM_PATHS-1:0]			rsp_valid,
	input wire logic					maint_set,
	input wire logic					maint_clear,
	input wire logic					maint_upper,
	input wire logic	[CHIP_SEL_W-1:0]		maint_chip,
	input wire spare_cfg_t					flaw_lo,
	input wire spare_cfg_t					flaw_hi,
	input wire logic	[LO_CHIPS*CHIP_W-1:0]		stack_wr_lo_log,
	input wire logic	[(LO_CHIPS+1)*CHIP_W-1:0]	stack_wr_lo_phys
);
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (!resetn);
	property p_pop_send;
		req_resume[0] |=> xbar_valid[0] != 4'h0;
	endproperty
	a_pop_send: assert property (p_pop_send) else $error("pop not sent");
	property p_send_pop;
		xbar_valid[0] != 4'h0 |-> $past(req_resume[0]);
	endproperty
	a_send_pop: assert property (p_send_pop) else $error("send without pop");
	property p_unit;
		xbar_valid[0] != 4'h0 |-> xbar_valid[0] == 4'h1 << xbar_ref[0].ctrl.bank[3:2];
	endproperty
	a_unit: assert property (p_unit) else $error("wrong crossbar unit");
	property p_ret;
		ret_resume[0] |=> rsp_valid[0];
	endproperty
	a_ret: assert property (p_ret) else $error("return not answered");
	property p_rst;
		$rose(resetn) |-> xbar_valid == '0 && rsp_valid == '0 && !flaw_lo.en && !flaw_hi.en;
	endproperty
	a_rst: assert property (p_rst) else $error("outputs not cleared");
	property p_set;
		maint_set && !maint_clear && !maint_upper && !flaw_lo.en && maint_chip < 5'h12
			|=> flaw_lo == {1'b1, $past(maint_chip)};
	endproperty
	a_set: assert property (p_set) else $error("flaw not taken");
	property p_keep;
		flaw_lo.en && !maint_clear |=> $stable(flaw_lo);
	endproperty
	a_keep: assert property (p_keep) else $error("flaw changed");
	property p_lane;
		!$past(flaw_lo.en) && $past(resetn) |-> stack_wr_lo_phys[LO_CHIPS*CHIP_W-1:0] == $past(stack_wr_lo_log);
	endproperty
	a_lane: assert property (p_lane) else $error("lanes moved");
endmodule : mem_ref_relay_assertions
bind mem_ref_relay mem_ref_relay_assertions chk_i (.*);
`default_nettype wire

// File: sim/mem_ref_relay_tb_top.sv
// self-checking testbench of the memory reference relay
`timescale 1ns/1ps
`default_nettype none
module mem_ref_relay_tb_top
	import mem_relay_pkg::*;
;
	logic				core_clk = 1'b0;
	logic				resetn = 1'b0;
	logic [NUM_PATHS-1:0]		req_valid, req_resume, ret_resume, rsp_valid, rsp_resume;
	logic [NUM_PATHS-1:0]		ret_valid = '0;
	ref_ctrl_t [NUM_PATHS-1:0]	req_ctrl;
	logic [NUM_PATHS-1:0][ADDR_W-1:0]	req_addr;
	logic [NUM_PATHS-1:0][PKT_W-1:0]	req_pkt;
	logic [NUM_PATHS-1:0][XBAR_UNITS-1:0]	xbar_valid, xbar_resume = '0;
	mem_ref_t [NUM_PATHS-1:0]	xbar_ref;
	mem_ret_t [NUM_PATHS-1:0]	ret_data = '0, rsp_data;
	logic				maint_set = 1'b0, maint_clear = 1'b0, maint_upper = 1'b0;
	logic				rsp_stall = 1'b0, xstall = 1'b0;
	logic [CHIP_SEL_W-1:0]		maint_chip = '0;
	spare_cfg_t			flaw_lo, flaw_hi;
	logic [LO_CHIPS*CHIP_W-1:0]	stack_wr_lo_log, stack_rd_lo_log;
	logic [HI_CHIPS*CHIP_W-1:0]	stack_wr_hi_log, stack_rd_hi_log;
	logic [(LO_CHIPS+1)*CHIP_W-1:0]	stack_wr_lo_phys, stack_rd_lo_phys;
	logic [(HI_CHIPS+1)*CHIP_W-1:0]	stack_wr_hi_phys, stack_rd_hi_phys;
	logic [4:0]			fl[5] = '{5'h00, 5'h11, 5'h01, 5'h12, 5'h13};
	mem_ref_t			exp_x[NUM_PATHS][$];
	mem_ret_t			exp_r[NUM_PATHS][$];
	int				fail_count = 0, cmp_count = 0, xs = 0, rs = 0, seed = 21466;
	int				xp[NUM_PATHS][XBAR_UNITS], sent[NUM_PATHS], back[NUM_PATHS];
	assign stack_rd_lo_phys = stack_wr_lo_phys;
	assign stack_rd_hi_phys = stack_wr_hi_phys;
	mem_ref_relay dut (.*);
	proc_board_model pm (.*);
	initial
		forever #12.5 core_clk = ~core_clk;
	task automatic chk(input logic [127:0] got, input logic [127:0] want);
		cmp_count++;
		if (got !== want)
		begin
			fail_count++;
			$display("BAD %0t got %h exp %h", $time, got, want);
		end
	endtask : chk
	task automatic complete_run();
		$display("checks %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : complete_run
	function automatic logic [127:0] rnd();
		return {$random(seed), $random(seed), $random(seed), $random(seed)};
	endfunction : rnd
	function automatic mem_ref_t mk_ref(input logic [127:0] v);
		mem_ref_t r;
		r = v[$bits(mem_ref_t)-1:0];
		if (!r.ctrl.write)
			r.word &= 76'h1C70000FFFF0000FFFF;
		return r;
	endfunction : mk_ref
	function automatic logic [127:0] map_wr(input int n, input int f, input logic [127:0] lg);
		logic [127:0] r;
		int d;
		r = '0;
		for (int k = 0; k < n; k++)
		begin
			d = (k < f || (k - f) % 2 != 0) ? k : (k + 2 < n ? k + 2 : n);
			r[4 * d +: 4] = lg[4 * k +: 4];
		end
		return r;
	endfunction : map_wr
	task automatic drain();
		int n;
		do
		begin
			@(negedge core_clk);
			n = 0;
			for (int p = 0; p < NUM_PATHS; p++)
				n += exp_x[p].size() + exp_r[p].size();
		end
		while (n > 0);
		repeat (4) @(negedge core_clk);
	endtask : drain
	task automatic ret_send(input mem_ret_t t);
		while (sent[0] - back[0] >= SLICE_DEPTH)
			@(negedge core_clk);
		@(negedge core_clk);
		ret_valid[0] = 1'b1;
		ret_data[0] = t;
		sent[0]++;
		@(negedge core_clk);
		ret_valid[0] = 1'b0;
		ret_data[0] = ~t;
	endtask : ret_send
	always @(negedge core_clk)
		for (int p = 0; p < NUM_PATHS; p++)
		begin
			back[p] += 32'(ret_resume[p]);
			if (xbar_valid[p] != 4'h0)
			begin
				xs++;
				chk(xbar_ref[p], exp_x[p][0]);
				chk(xbar_valid[p], 4'h1 << exp_x[p][0].ctrl.bank[3:2]);
				void'(exp_x[p].pop_front());
			end
			if (rsp_valid[p])
			begin
				rs++;
				chk(rsp_data[p], exp_r[p][0]);
				void'(exp_r[p].pop_front());
			end
			for (int u = 0; u < XBAR_UNITS; u++)
			begin
				xp[p][u] += 32'(xbar_valid[p][u]);
				xbar_resume[p][u] <= xp[p][u] > 0 && !xstall;
				if (xp[p][u] > 0 && !xstall)
					xp[p][u]--;
			end
		end
	initial
	begin
		repeat (5000) @(posedge core_clk);
		fail_count++;
		complete_run();
	end
	initial
	begin
		mem_ref_t r;
		mem_ret_t t;
		logic [127:0] v;
		int n;
		v = rnd();
		stack_wr_lo_log = v[71:0];
		stack_wr_hi_log = v[127:48];
		repeat (6) @(negedge core_clk);
		resetn = 1'b1;
		for (int i = 0; i < 160; i++)
		begin
			r = mk_ref(rnd());
			exp_x[i % NUM_PATHS].push_back(r);
			pm.send(i % NUM_PATHS, r);
		end
		drain();
		$display("test traffic done");
		xstall = 1'b1;
		n = xs;
		for (int i = 0; i < 10; i++)
		begin
			r = mk_ref(rnd());
			r.ctrl.bank[3:2] = 2'h0;
			exp_x[0].push_back(r);
			pm.send(0, r);
		end
		repeat (60) @(negedge core_clk);
		chk(xs - n, XBAR_BUFS);
		xstall = 1'b0;
		drain();
		$display("test crossbar stall done");
		rsp_stall = 1'b1;
		n = rs;
		for (int i = 0; i < 8; i++)
		begin
			v = rnd();
			t = v[$bits(mem_ret_t)-1:0];
			exp_r[0].push_back(t);
			ret_send(t);
		end
		repeat (20) @(negedge core_clk);
		chk(rs - n, PROC_BUFS);
		rsp_stall = 1'b0;
		drain();
		$display("test read return done");
		for (int i = 0; i < 5; i++)
		begin
			maint_upper = i > 1;
			maint_clear = 1'b1;
			@(negedge core_clk);
			maint_clear = 1'b0;
			maint_set = 1'b1;
			maint_chip = maint_upper ? 5'h14 : 5'h12;
			@(negedge core_clk);
			maint_chip = fl[i];
			@(negedge core_clk);
			maint_chip = fl[i] ^ 5'h01;
			@(negedge core_clk);
			maint_set = 1'b0;
			v = rnd();
			stack_wr_lo_log = v[71:0];
			stack_wr_hi_log = v[127:48];
			repeat (4) @(negedge core_clk);
			chk(maint_upper ? flaw_hi : flaw_lo, {1'b1, fl[i]});
			chk(maint_upper ? stack_wr_hi_phys : stack_wr_lo_phys, map_wr(maint_upper ? HI_CHIPS : LO_CHIPS, fl[i],
				maint_upper ? stack_wr_hi_log : stack_wr_lo_log));
			chk(maint_upper ? stack_rd_hi_log : stack_rd_lo_log, maint_upper ? stack_wr_hi_log : stack_wr_lo_log);
		end
		$display("test sparing done");
		complete_run();
	end
endmodule : mem_ref_relay_tb_top
`default_nettype wire

// File: sim/proc_board_model.sv
// processor board model: issues references on every path and takes read answers
`timescale 1ns/1ps
`default_nettype none
module proc_board_model
	import mem_relay_pkg::*;
(
	input wire logic				core_clk,
	input wire logic				resetn,
	output logic		[NUM_PATHS-1:0]		req_valid,
	output ref_ctrl_t	[NUM_PATHS-1:0]		req_ctrl,
	output logic		[NUM_PATHS-1:0][ADDR_W-1:0]	req_addr,
	output logic		[NUM_PATHS-1:0][PKT_W-1:0]	req_pkt,
	input wire logic	[NUM_PATHS-1:0]		req_resume,
	input wire logic	[NUM_PATHS-1:0]		rsp_valid,
	output logic		[NUM_PATHS-1:0]		rsp_resume,
	input wire logic				rsp_stall
);
	mem_ref_t		q[NUM_PATHS][$];
	mem_ref_t		cur[NUM_PATHS];
	logic [CNT_W-1:0]	out_reg[NUM_PATHS];
	logic			ph[NUM_PATHS] = '{default: 1'b0};
	int			pend[NUM_PATHS] = '{default: 0};
	task automatic send(input int p, input mem_ref_t r);
		q[p].push_back(r);
	endtask : send
	always @(posedge core_clk or negedge resetn)
		for (int p = 0; p < NUM_PATHS; p++)
			out_reg[p] <= !resetn ? 3'h0 : out_reg[p] + 3'(req_valid[p]) - 3'(req_resume[p]);
	always @(negedge core_clk)
		for (int p = 0; p < NUM_PATHS; p++)
		begin
			pend[p] = pend[p] + 32'(rsp_valid[p]);
			rsp_resume[p] <= pend[p] > 0 && !rsp_stall;
			if (pend[p] > 0 && !rsp_stall)
				pend[p]--;
			if (ph[p])
			begin
				req_pkt[p] <= {cur[p].word[75:73], cur[p].word[69:67], cur[p].word[63:48], cur[p].word[31:16]};
				req_valid[p] <= 1'b0;
				ph[p] = 1'b0;
			end
			else if (resetn && q[p].size() > 0 && out_reg[p] < PROC_BUFS)
			begin
				cur[p] = q[p].pop_front();
				req_valid[p] <= 1'b1;
				req_ctrl[p] <= cur[p].ctrl;
				req_addr[p] <= cur[p].addr;
				req_pkt[p] <= {cur[p].word[72:70], cur[p].word[66:64], cur[p].word[47:32], cur[p].word[15:0]};
				ph[p] = cur[p].ctrl.write;
			end
			else
			begin
				req_valid[p] <= 1'b0;
				req_pkt[p] <= ~req_pkt[p];
				req_addr[p] <= ~req_addr[p];
			end
		end
endmodule : proc_board_model
`default_nettype wire
